// ### inc/tpec_defines.svh
// Register offsets, field positions, reset values of the event counter.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
`ifndef TPEC_DEFINES_SVH
`define TPEC_DEFINES_SVH

// Byte offsets of the registers
`define TPEC_OFS_START 8'h00
`define TPEC_OFS_COUNT 8'h04
`define TPEC_OFS_MODE 8'h08
`define TPEC_OFS_TRIG 8'h0C
`define TPEC_OFS_STAT 8'h10
`define TPEC_OFS_MASK 8'h14

// count_start_flag_reg fields
`define TPEC_START_BIT 0

// channel2_mode_reg fields
`define TPEC_MODE_FREE 0
`define TPEC_MODE_TWO_PH 1
`define TPEC_MODE_UD_PIN 2
`define TPEC_MODE_SW_DOWN 3
`define TPEC_MODE_FALL_EDGE 4
`define TPEC_MODE_W 5

// trigger_select_reg fields
`define TPEC_TRIG_LO 0
`define TPEC_TRIG_HI 1

// Status and mask fields
`define TPEC_ST_OVF 0
`define TPEC_ST_UNF 1
`define TPEC_ST_W 2

// Reset values and counter limits
`define TPEC_MODE_RST 5'h00
`define TPEC_TRIG_RST 2'h0
`define TPEC_CNT_RST 16'h0000
`define TPEC_CNT_MAX 16'hFFFF
`define TPEC_CNT_MIN 16'h0000
`define TPEC_CNT_ONE 16'h0001
`define TPEC_WORD_ZERO 32'h0000_0000

`endif

// ### inc/tpec_pkg.sv
// Types shared by the event counter design files.
// Assumes tpec_defines.svh supplies the numeric constants.
package tpec_pkg;
  typedef logic [7:0] tpec_addr_t;
  typedef logic [31:0] tpec_word_t;
  typedef logic [15:0] tpec_cnt_t;
  // Count source, ordered as the two trigger select bits encode it
  typedef enum logic [1:0] {
    SRC_PIN,
    SRC_ADJ_LO,
    SRC_ADJ_HI,
    SRC_GRP2
  } tpec_src_t;
endpackage : tpec_pkg

// ### hdl/tpec_pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one per pin.
// Assumes asynchronous pin inputs and the single system clock.
`timescale 1ns/1ps
module tpec_pin_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Pins and filtered levels
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  import tpec_pkg::*;

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      wire agree = (s2 == s3);
      always_ff @(posedge clk_i)
      begin
        s1 <= pin_i[g];
        s2 <= s1;
        s3 <= s2;
      end
      // Level follows only once second and third stages agree
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          level_o[g] <= 1'b0;
        else if (agree)
          level_o[g] <= s3;
      end
    end
  endgenerate
endmodule : tpec_pin_sync

// ### hdl/tpec_counter.sv
// 16-bit event counter channel with two-phase decoding, Avalon-MM slave.
// Assumes pins asynchronous, neighbour timer events one-cycle pulses
// on clk_i.
`timescale 1ns/1ps
`include "tpec_defines.svh"

module tpec_counter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Avalon-MM slave
  input wire tpec_pkg::tpec_addr_t avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire tpec_pkg::tpec_word_t avs_writedata_i,
  output tpec_pkg::tpec_word_t avs_readdata_o,
  output logic avs_waitrequest_o,
  // Pins: phase a and phase b in two-phase mode
  input wire logic timer_in_pin_i,
  input wire logic timer_out_pin_i,
  // Overflow or underflow pulses of other timers
  input wire logic adj_lo_ev_i,
  input wire logic adj_hi_ev_i,
  input wire logic grp2_ev_i,
  // Interrupt
  output logic irq_o
);
  import tpec_pkg::*;

  // Register state
  logic run;
  logic [`TPEC_MODE_W-1:0] mode;
  logic [1:0] trig_sel;
  tpec_cnt_t cnt;
  tpec_cnt_t reload;
  logic first_seen;
  logic [`TPEC_ST_W-1:0] status;
  logic [`TPEC_ST_W-1:0] mask;
  logic [1:0] pin_q;

  // Pin synchroniser
  logic [1:0] pin_lvl;
  tpec_pin_sync #(
    .W(2)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pin_i({timer_out_pin_i, timer_in_pin_i}),
    .level_o(pin_lvl)
  );

  // Bus decode
  wire bus_req = avs_read_i | avs_write_i;
  wire acc = bus_req & ~avs_waitrequest_o;
  wire wr_acc = acc & avs_write_i;
  wire rd_take = avs_read_i & avs_waitrequest_o;
  wire sel_start = (avs_address_i == `TPEC_OFS_START);
  wire sel_count = (avs_address_i == `TPEC_OFS_COUNT);
  wire sel_mode = (avs_address_i == `TPEC_OFS_MODE);
  wire sel_trig = (avs_address_i == `TPEC_OFS_TRIG);
  wire sel_stat = (avs_address_i == `TPEC_OFS_STAT);
  wire sel_mask = (avs_address_i == `TPEC_OFS_MASK);
  wire [31:0] be_mask = {{8{avs_byteenable_i[3]}},
                         {8{avs_byteenable_i[2]}},
                         {8{avs_byteenable_i[1]}},
                         {8{avs_byteenable_i[0]}}};
  wire [31:0] wd = avs_writedata_i & be_mask;
  wire wr_start = wr_acc & sel_start & avs_byteenable_i[0];
  wire wr_count = wr_acc & sel_count;
  wire wr_mode = wr_acc & sel_mode & avs_byteenable_i[0];
  wire wr_trig = wr_acc & sel_trig & avs_byteenable_i[0];
  wire wr_stat = wr_acc & sel_stat & avs_byteenable_i[0];
  wire wr_mask = wr_acc & sel_mask & avs_byteenable_i[0];
  wire tpec_cnt_t wr_cnt_val = (reload & ~be_mask[15:0]) | wd[15:0];

  // Mode fields
  wire free_run = mode[`TPEC_MODE_FREE];
  wire two_ph = mode[`TPEC_MODE_TWO_PH];
  wire ud_pin = mode[`TPEC_MODE_UD_PIN];
  wire sw_down = mode[`TPEC_MODE_SW_DOWN];
  wire fall_edge = mode[`TPEC_MODE_FALL_EDGE];
  wire tpec_src_t src = tpec_src_t'(trig_sel);

  // Pin edges
  wire phase_a = pin_lvl[0];
  wire phase_b = pin_lvl[1];
  wire a_rise = phase_a & ~pin_q[0];
  wire a_fall = ~phase_a & pin_q[0];
  wire pin_edge = fall_edge ? a_fall : a_rise;

  // Two-phase decode, direction from phase relation
  wire tp_ev = phase_b & (a_rise | a_fall);
  wire tp_up = a_rise;

  // Single-phase source select and direction
  logic sp_ev;
  always_comb
  begin
    case (src)
      SRC_PIN: sp_ev = pin_edge;
      SRC_ADJ_LO: sp_ev = adj_lo_ev_i;
      SRC_ADJ_HI: sp_ev = adj_hi_ev_i;
      SRC_GRP2: sp_ev = grp2_ev_i;
      default: sp_ev = 1'b0;
    endcase
  end
  wire pin_dir = ud_pin & (src == SRC_PIN);
  wire sp_up = pin_dir ? phase_b : ~sw_down;

  wire ev_src = two_ph ? tp_ev : sp_ev;
  wire cnt_up = two_ph ? tp_up : sp_up;
  wire cnt_ev = run & ev_src;
  wire at_max = (cnt == `TPEC_CNT_MAX);
  wire at_min = (cnt == `TPEC_CNT_MIN);
  wire ovf = cnt_ev & cnt_up & at_max;
  wire unf = cnt_ev & ~cnt_up & at_min;

  // Next counter value
  tpec_cnt_t next_cnt;
  always_comb
  begin
    next_cnt = cnt;
    if (cnt_ev)
    begin
      if (ovf)
        next_cnt = free_run ? `TPEC_CNT_MIN : reload;
      else if (unf)
        next_cnt = free_run ? `TPEC_CNT_MAX : reload;
      else if (cnt_up)
        next_cnt = cnt + `TPEC_CNT_ONE;
      else
        next_cnt = cnt - `TPEC_CNT_ONE;
    end
    else if (wr_count & ~first_seen)
      next_cnt = wr_cnt_val;
  end

  // Sticky status, set wins over write-one-to-clear
  wire [`TPEC_ST_W-1:0] st_set = {unf, ovf};
  wire [`TPEC_ST_W-1:0] st_clr = wr_stat ? wd[`TPEC_ST_W-1:0] : '0;
  wire [`TPEC_ST_W-1:0] next_status = (status & ~st_clr) | st_set;

  // Read mux
  tpec_word_t rd_val;
  always_comb
  begin
    rd_val = `TPEC_WORD_ZERO;
    if (sel_start)
      rd_val[`TPEC_START_BIT] = run;
    else if (sel_count)
      rd_val[15:0] = cnt;
    else if (sel_mode)
      rd_val[`TPEC_MODE_W-1:0] = mode;
    else if (sel_trig)
      rd_val[1:0] = trig_sel;
    else if (sel_stat)
      rd_val[`TPEC_ST_W-1:0] = status;
    else if (sel_mask)
      rd_val[`TPEC_ST_W-1:0] = mask;
  end

  // Bus handshake: one wait cycle per request
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= `TPEC_WORD_ZERO;
    end
    else
    begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
      if (rd_take)
        avs_readdata_o <= rd_val;
    end
  end

  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      run <= 1'b0;
      mode <= `TPEC_MODE_RST;
      trig_sel <= `TPEC_TRIG_RST;
      mask <= '0;
    end
    else
    begin
      if (wr_start)
        run <= wd[`TPEC_START_BIT];
      if (wr_mode)
        mode <= wd[`TPEC_MODE_W-1:0];
      if (wr_trig)
        trig_sel <= wd[1:0];
      if (wr_mask)
        mask <= wd[`TPEC_ST_W-1:0];
    end
  end

  // Counter, reload and first-event tracking
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt <= `TPEC_CNT_RST;
      reload <= `TPEC_CNT_RST;
      first_seen <= 1'b0;
      pin_q <= 2'b00;
    end
    else
    begin
      cnt <= next_cnt;
      pin_q <= pin_lvl;
      if (wr_count)
        reload <= wr_cnt_val;
      if (~run | (wr_start & ~wd[`TPEC_START_BIT]))
        first_seen <= 1'b0;
      else if (cnt_ev)
        first_seen <= 1'b1;
    end
  end

  // Interrupt state
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      status <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      status <= next_status;
      irq_o <= |(next_status & mask);
    end
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  AST_STOP_HOLD:
    assert property (!run && !wr_count |=> $stable(cnt))
    else $error("counter moved while stopped");

  AST_UP_INC:
    assert property (cnt_ev && cnt_up && !at_max
                     |=> cnt == $past(cnt) + `TPEC_CNT_ONE)
    else $error("up count did not add one");

  AST_DN_DEC:
    assert property (cnt_ev && !cnt_up && !at_min
                     |=> cnt == $past(cnt) - `TPEC_CNT_ONE)
    else $error("down count did not subtract one");

  AST_RELOAD:
    assert property ((ovf || unf) && !free_run |=> cnt == $past(reload))
    else $error("reload not taken on wrap");

  AST_FREE_WRAP:
    assert property (ovf && free_run |=> cnt == `TPEC_CNT_MIN)
    else $error("free-run overflow did not wrap to zero");

  AST_FREE_UNF:
    assert property (unf && free_run |=> cnt == `TPEC_CNT_MAX)
    else $error("free-run underflow did not wrap to max");

  AST_IRQ_FLAG:
    assert property (ovf && mask[`TPEC_ST_OVF] |=> irq_o)
    else $error("overflow did not raise interrupt");

  AST_WR_BOTH:
    assert property (wr_count && !first_seen && !cnt_ev
                     |=> cnt == reload)
    else $error("early write did not load counter");

  AST_WR_RELOAD:
    assert property (wr_count && first_seen && !cnt_ev
                     |=> $stable(cnt))
    else $error("late write changed counter");

  AST_TWO_PH:
    assert property (two_ph && phase_b && a_rise |-> ev_src && cnt_up)
    else $error("two-phase rise not counted up");

  AST_PIN_DIR:
    assert property (!two_ph && pin_dir |-> cnt_up == phase_b)
    else $error("pin direction not followed");

  AST_READ:
    assert property (rd_take && sel_count
                     |=> avs_readdata_o == {16'h0000, $past(cnt)})
    else $error("count read mismatch");

endmodule : tpec_counter

// ### tb/tpec_pulse_src.sv
// Pulse source model for the two counter pins.
// Assumes the bench calls set_pins; clk_i is the system clock.
`timescale 1ns/1ps
module tpec_pulse_src (
  // Clock
  input wire logic clk_i,
  // Pins, inputs of the counter
  output logic pin_a_o,
  output logic pin_b_o
);
  initial
  begin
    pin_a_o = 1'b0;
    pin_b_o = 1'b0;
  end
  // Levels change after an edge and hold past the pin filter
  task automatic set_pins(input logic a, input logic b);
    @(posedge clk_i);
    pin_a_o <= a;
    pin_b_o <= b;
    repeat (8) @(posedge clk_i);
  endtask : set_pins
endmodule : tpec_pulse_src

// ### tb/two_phase_event_counter_tb.sv
// Self-checking bench of the event counter.
// Assumes tpec_counter, tpec_pkg and the pulse source model.
`timescale 1ns/1ps
`include "tpec_defines.svh"
module two_phase_event_counter_tb;
  import tpec_pkg::*;
  logic clk_i, srst_i, rd, wr, wq, irq;
  tpec_addr_t adr;
  tpec_word_t wd, rdat;
  logic [2:0] ev;
  logic pa, pb;
  int fails, comparisons, cyc;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t got %h expected %h", $time, a, b); end end
  tpec_counter DUT (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(4'hF),
    .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
    .timer_in_pin_i(pa), .timer_out_pin_i(pb), .adj_lo_ev_i(ev[0]),
    .adj_hi_ev_i(ev[1]), .grp2_ev_i(ev[2]), .irq_o(irq));
  tpec_pulse_src SRC (.clk_i(clk_i), .pin_a_o(pa), .pin_b_o(pb));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    if (fails == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict();
    end
  end
  task automatic bus(input logic w, input tpec_addr_t a, input tpec_word_t d,
    output tpec_word_t q);
    @(posedge clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk_i); while (wq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic bus_wr(input tpec_addr_t a, input tpec_word_t d);
    tpec_word_t q;
    bus(1'b1, a, d, q);
  endtask : bus_wr
  task automatic rd_chk(input tpec_addr_t a, input tpec_word_t e);
    tpec_word_t q;
    bus(1'b0, a, 32'h0000_0000, q);
    `CHK(q, e)
  endtask : rd_chk
  task automatic irq_chk(input logic e);
    repeat (2) @(negedge clk_i);
    `CHK(irq, e)
  endtask : irq_chk
  task automatic t_reset();
    rd_chk(`TPEC_OFS_MODE, 32'h0000_0000);
    rd_chk(`TPEC_OFS_TRIG, 32'h0000_0000);
    rd_chk(`TPEC_OFS_STAT, 32'h0000_0000);
    rd_chk(8'h40, 32'h0000_0000);
    irq_chk(1'b0);
  endtask : t_reset
  task automatic t_up_reload();
    bus_wr(`TPEC_OFS_MASK, 32'h0000_0003);
    bus_wr(`TPEC_OFS_COUNT, 32'h0000_FFFE);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_FFFE);
    bus_wr(`TPEC_OFS_START, 32'h0000_0001);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_FFFE);
    SRC.set_pins(1'b1, 1'b1);
    SRC.set_pins(1'b0, 1'b1);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_FFFF);
    bus_wr(`TPEC_OFS_COUNT, 32'h0000_1234);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_FFFF);
    irq_chk(1'b0);
    SRC.set_pins(1'b1, 1'b1);
    SRC.set_pins(1'b0, 1'b1);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_1234);
    rd_chk(`TPEC_OFS_STAT, 32'h0000_0001);
    irq_chk(1'b1);
    bus_wr(`TPEC_OFS_STAT, 32'h0000_0001);
    irq_chk(1'b0);
  endtask : t_up_reload
  task automatic t_stop();
    bus_wr(`TPEC_OFS_START, 32'h0000_0000);
    SRC.set_pins(1'b1, 1'b1);
    SRC.set_pins(1'b0, 1'b1);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_1234);
  endtask : t_stop
  task automatic t_dir_src();
    bus_wr(`TPEC_OFS_COUNT, 32'h0000_0001);
    bus_wr(`TPEC_OFS_MODE, 32'h0000_0004);
    bus_wr(`TPEC_OFS_START, 32'h0000_0001);
    SRC.set_pins(1'b1, 1'b0);
    SRC.set_pins(1'b0, 1'b0);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_0000);
    SRC.set_pins(1'b1, 1'b0);
    SRC.set_pins(1'b0, 1'b0);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_0001);
    rd_chk(`TPEC_OFS_STAT, 32'h0000_0002);
    for (int i = 0; i < 3; i++)
    begin
      bus_wr(`TPEC_OFS_TRIG, tpec_word_t'(i + 1));
      @(posedge clk_i);
      ev <= 3'(1 << i);
      @(posedge clk_i);
      ev <= 3'h0;
      rd_chk(`TPEC_OFS_COUNT, tpec_word_t'(i + 2));
    end
  endtask : t_dir_src
  task automatic t_free();
    bus_wr(`TPEC_OFS_START, 32'h0000_0000);
    bus_wr(`TPEC_OFS_TRIG, 32'h0000_0000);
    bus_wr(`TPEC_OFS_COUNT, 32'h0000_0000);
    bus_wr(`TPEC_OFS_MODE, 32'h0000_0005);
    bus_wr(`TPEC_OFS_START, 32'h0000_0001);
    SRC.set_pins(1'b1, 1'b0);
    SRC.set_pins(1'b0, 1'b0);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_FFFF);
    SRC.set_pins(1'b1, 1'b1);
    SRC.set_pins(1'b0, 1'b1);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_0000);
  endtask : t_free
  task automatic t_two_phase();
    bus_wr(`TPEC_OFS_START, 32'h0000_0000);
    bus_wr(`TPEC_OFS_COUNT, 32'h0000_0010);
    bus_wr(`TPEC_OFS_MODE, 32'h0000_0002);
    bus_wr(`TPEC_OFS_START, 32'h0000_0001);
    SRC.set_pins(1'b1, 1'b1);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_0011);
    SRC.set_pins(1'b0, 1'b1);
    SRC.set_pins(1'b0, 1'b0);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_0010);
    SRC.set_pins(1'b1, 1'b0);
    SRC.set_pins(1'b0, 1'b0);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_0010);
  endtask : t_two_phase
  task automatic t_sw_edge();
    bus_wr(`TPEC_OFS_START, 32'h0000_0000);
    bus_wr(`TPEC_OFS_COUNT, 32'h0000_0005);
    bus_wr(`TPEC_OFS_MODE, 32'h0000_0018);
    bus_wr(`TPEC_OFS_START, 32'h0000_0001);
    SRC.set_pins(1'b1, 1'b0);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_0005);
    SRC.set_pins(1'b0, 1'b0);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_0004);
  endtask : t_sw_edge
  task automatic t_mid_reset();
    irq_chk(1'b1);
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd_chk(`TPEC_OFS_COUNT, 32'h0000_0000);
    rd_chk(`TPEC_OFS_STAT, 32'h0000_0000);
    irq_chk(1'b0);
  endtask : t_mid_reset
  initial
  begin
    srst_i = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0000_0000;
    ev = 3'h0;
    fails = 0;
    comparisons = 0;
    cyc = 0;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_up_reload();
    t_stop();
    t_dir_src();
    t_free();
    t_two_phase();
    t_sw_edge();
    t_mid_reset();
    print_verdict();
  end
endmodule : two_phase_event_counter_tb
